// [flblk_defs.svh]
// Constants for the flash lock and status host controller
`ifndef FLBLK_DEFS_SVH
`define FLBLK_DEFS_SVH
// Host register offsets (word index on the local port)
`define FLBLK_REG_CTRL 4'h0
`define FLBLK_REG_ADDR 4'h1
`define FLBLK_REG_WDATA 4'h2
`define FLBLK_REG_RESULT 4'h3
`define FLBLK_REG_STATUS 4'h4
`define FLBLK_REG_LOCK 4'h5
// Control register fields
`define FLBLK_CTRL_GO 0
`define FLBLK_CTRL_CMD_LO 1
`define FLBLK_CTRL_CMD_HI 3
`define FLBLK_CTRL_WP 4
// Status register bit positions on the flash
`define FLBLK_SR_READY 7
`define FLBLK_SR_ERS_SUSP 6
`define FLBLK_SR_ERS_ERR 5
`define FLBLK_SR_PRG_ERR 4
`define FLBLK_SR_VPP_LOW 3
`define FLBLK_SR_PRG_SUSP 2
`define FLBLK_SR_LOCK_ABORT 1
`define FLBLK_SR_VALID_MASK 16'h00FE
`define FLBLK_XSR_AVAIL 7
`define FLBLK_XSR_VALID_MASK 16'h0080
`define FLBLK_PCR_LO 8
`define FLBLK_PCR_HI 10
// Flash command codes
`define FLBLK_CMD_READ_ARRAY 16'h00FF
`define FLBLK_CMD_READ_SR 16'h0070
`define FLBLK_CMD_LOCK_SETUP 16'h0060
`define FLBLK_CMD_LOCK_SET 16'h0001
`define FLBLK_CMD_LOCK_CLR 16'h00D0
`define FLBLK_CMD_LOCK_DOWN 16'h002F
`define FLBLK_CMD_READ_ID 16'h0090
`define FLBLK_CMD_PAGE_PRG 16'h00E8
`define FLBLK_CMD_CLR_SR 16'h0050
// Bus timing: strobe width and access time in ns, and cycles at 4 ns
`define FLBLK_T_WE_NS 60
`define FLBLK_T_ACC_NS 90
`define FLBLK_CLK_NS 4
`define FLBLK_WE_CYC 4'((`FLBLK_T_WE_NS + `FLBLK_CLK_NS - 1) / `FLBLK_CLK_NS)
`define FLBLK_ACC_CYC 5'((`FLBLK_T_ACC_NS + `FLBLK_CLK_NS - 1) / `FLBLK_CLK_NS)
`define FLBLK_ID_OFFSET 22'h000002
`define FLBLK_PCR_ADDR 22'h000006
`endif

// [flblk_flash_model.sv]
// Behavioural flash device: block locks and status words
`timescale 1ns/100ps
module flblk_flash_model (
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_wp_n,
  output logic [15:0] flash_dq_in,
  output logic ready_busy_n_output
);
  logic [1:0] lock_r [128]; // {lock-down, lock} per block
  logic was110_r [128]; // Down state entered from [110]
  logic [15:0] sr_r = 16'h0080; // Status word, ready
  logic [1:0] mode_r = 2'h0; // Read mode: array, status, ident, extended
  logic setup_r = 1'b0; // Lock setup word seen
  logic [15:0] rd_val;
  logic [6:0] blk;
  assign blk = flash_addr[21:15];
  logic busy_r = 1'b0; // Engine busy after a lock confirm
  logic pb_free_r = 1'b0; // Page buffer free, toggles on each check
  assign ready_busy_n_output = !busy_r; // Low while busy
  // Busy lasts long enough that the host's first status read sees it
  always @(posedge busy_r) begin
    #300 busy_r = 1'b0;
  end
  // Power-up: every block locked, not down
  initial begin
    for (int i = 0; i < 128; i++) begin
      lock_r[i] = 2'b01;
      was110_r[i] = 1'b0;
    end
  end
  // Reserved bits read as ones, and as 14'h2AAA above the lock code, so the host must mask them
  always_comb begin
    case (mode_r)
      2'h1: rd_val = (sr_r & 16'hFF7F) | {8'h00, !busy_r, 7'h00} | 16'hFF01;
      2'h2: rd_val = (flash_addr[15:0] == 16'h0006) ? 16'hF9FF
        : {14'h2AAA, lock_r[blk]};
      2'h3: rd_val = pb_free_r ? 16'hFFFF : 16'hFF7F; // Reserved bits high
      default: rd_val = 16'h1234;
    endcase
  end
  // Released bus shows the inverse, never a stale value
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd_val : ~rd_val;
  // Command words land on the rising write strobe
  always @(posedge flash_we_n) begin
    if (setup_r) begin
      case (flash_dq_out)
        16'h0001: lock_r[blk][0] = 1'b1;
        16'h00D0: if (!(lock_r[blk][1] && !flash_wp_n)) lock_r[blk][0] = 1'b0;
        16'h002F: begin
          lock_r[blk] = 2'b11;
          was110_r[blk] = 1'b0;
        end
        default: sr_r[5:4] = 2'b11;
      endcase
      setup_r = 1'b0;
      busy_r = 1'b1;
    end else begin
      case (flash_dq_out)
        16'h0060: setup_r = 1'b1;
        16'h0070: mode_r = 2'h1;
        16'h0090: mode_r = 2'h2;
        16'h00E8: begin
          mode_r = 2'h3;
          pb_free_r = !pb_free_r;
        end
        16'h0050: sr_r = 16'h0080;
        default: mode_r = 2'h0;
      endcase
    end
  end
  // Protect pin fall relocks every locked-down block; rise unlocks again only those the fall relocked
  always @(posedge flash_wp_n) begin
    for (int i = 0; i < 128; i++) begin
      if (lock_r[i] == 2'b11) lock_r[i] = was110_r[i] ? 2'b10 : 2'b11;
    end
  end
  always @(negedge flash_wp_n) begin
    for (int i = 0; i < 128; i++) begin
      was110_r[i] = (lock_r[i] == 2'b10);
      if (lock_r[i][1]) lock_r[i] = 2'b11;
    end
  end
endmodule : flblk_flash_model

// [flblk_host.sv]
// Host controller driving flash lock commands and reading status
// Functional notes
// R1 - Set-lock locks unlocked blocks
// R2 - Clear-lock unlocks blocks not locked down
// R3 - Lock-down moves block to locked-down state
// R4 - Lock-down on unlocked block also locks
// R5 - Write-protect rise lifts lock-down protection
// R6 - Write-protect fall relocks and locks down
// R7 - Status bit 7 one means ready
// R8 - Status bit 6 marks erase suspended
// R9 - Status bit 5 marks erase failure
// R10 - Status bit 4 marks program failure
// R11 - Status bit 3 marks low supply abort
// R12 - Status bit 2 marks program suspended
// R13 - Status bit 1 marks locked block abort
// R14 - Host masks reserved status bits
// R15 - Status is per partition, not engine
// R16 - Low bits invalid while bit 7 zero
// R17 - Bits 5 and 4 mean bad sequence
// R18 - Supply checked only after erase/program
// R19 - Lock bit checked only after erase/program
// R20 - Extended bit 7 shows buffer accepted
// R21 - Reissue buffer command when not available
// R22 - Host masks reserved extended status bits
// R23 - Partition field in configuration bits 10:8
// R24 - Partition field defaults by parameter location
// R25 - Reset leaves every block locked
// R26 - Lock evaluated against write-protect level
`timescale 1ns/100ps
`include "flblk_defs.svh"
module flblk_host
  import flblk_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [21:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_wp_n,
  input wire logic ready_busy_n_output
);
  // Software-visible control state
  logic [2:0] op_r; // Operation picked by software
  logic [21:0] tgt_addr_r; // Block or partition address
  logic wp_r; // Requested write-protect level
  logic busy_r; // Sequence in progress
  logic [15:0] result_r; // Masked word read from the flash
  logic err_bad_seq_r; // Improper sequence seen
  logic avail_r; // Page buffer accepted
  logic [2:0] part_r; // Last partition field read
  logic [1:0] lock_r; // Last lock code read
  flblk_state_t state_r, state_nxt;
  logic [4:0] cnt_r; // Timing counter for strobes
  logic [1:0] step_r; // Write cycle within sequence
  logic [15:0] dq_s; // Synchronised data bus
  logic rb_s; // Synchronised ready/busy
  // Flash pins cross into sys_clk before any use
  flblk_sync #(.W(17)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .d({ready_busy_n_output, flash_dq_in}),
    .q({rb_s, dq_s})
  );
  // Decode of the local port
  wire wr_ctrl = reg_wr && (reg_addr == `FLBLK_REG_CTRL);
  wire wr_addr = reg_wr && (reg_addr == `FLBLK_REG_ADDR);
  wire go = wr_ctrl && reg_wdata[`FLBLK_CTRL_GO] && !busy_r;
  wire flblk_op_t op_e = flblk_op_t'(op_r);
  // Lock commands are two writes; reads are one write then one read
  wire two_wr = (op_e == FLBLK_OP_LOCK_SET) || (op_e == FLBLK_OP_LOCK_CLR)
             || (op_e == FLBLK_OP_LOCK_DOWN);
  wire has_rd = !two_wr && (op_e != FLBLK_OP_CLR_SR);
  // First write command of each operation
  wire [15:0] cmd0 = two_wr ? `FLBLK_CMD_LOCK_SETUP :
                     (op_e == FLBLK_OP_READ_LOCK || op_e == FLBLK_OP_READ_PCR)
                       ? `FLBLK_CMD_READ_ID :
                     (op_e == FLBLK_OP_PAGE_CHECK) ? `FLBLK_CMD_PAGE_PRG :
                     (op_e == FLBLK_OP_CLR_SR) ? `FLBLK_CMD_CLR_SR :
                     `FLBLK_CMD_READ_SR;
  // Confirm code picks the lock transition the device applies [R1] [R2] [R3] [R4]
  wire [15:0] cmd1 = (op_e == FLBLK_OP_LOCK_SET) ? `FLBLK_CMD_LOCK_SET :
                     (op_e == FLBLK_OP_LOCK_CLR) ? `FLBLK_CMD_LOCK_CLR :
                     `FLBLK_CMD_LOCK_DOWN;
  wire [15:0] wcmd = (step_r == 2'h0) ? cmd0 : cmd1;
  // Read address: lock code sits two words above the block base
  wire [21:0] lock_rd_addr = 22'(tgt_addr_r + `FLBLK_ID_OFFSET); // Wraps at the top word
  wire [21:0] rd_addr = (op_e == FLBLK_OP_READ_LOCK) ? lock_rd_addr :
                        (op_e == FLBLK_OP_READ_PCR)
                          ? {tgt_addr_r[21:16], 16'(`FLBLK_PCR_ADDR)} : tgt_addr_r;
  // Reserved bits are masked before software sees them [R14] [R22]
  wire [15:0] sr_m = dq_s & `FLBLK_SR_VALID_MASK;
  wire [15:0] xsr_m = dq_s & `FLBLK_XSR_VALID_MASK;
  // Bad-sequence pattern is both error bits together [R17]
  wire bad_seq = sr_m[`FLBLK_SR_ERS_ERR] && sr_m[`FLBLK_SR_PRG_ERR];
  wire strobe_done = (state_r == FLBLK_WR) ? (cnt_r == `FLBLK_WE_CYC)
                                           : (cnt_r == `FLBLK_ACC_CYC);
  // Next-state selection for the bus sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FLBLK_IDLE: begin
        if (go) begin
          state_nxt = FLBLK_WR;
        end
      end
      FLBLK_WR: begin
        if (strobe_done) begin
          state_nxt = FLBLK_WR_GAP;
        end
      end
      FLBLK_WR_GAP: begin
        if (two_wr && step_r == 2'h0) begin
          state_nxt = FLBLK_WR;
        end else if (has_rd) begin
          state_nxt = FLBLK_RD;
        end else begin
          state_nxt = FLBLK_DONE;
        end
      end
      FLBLK_RD: begin
        // Status low bits mean nothing while busy, so hold until ready [R16] [R15]
        if (strobe_done && (op_e != FLBLK_OP_READ_SR || dq_s[`FLBLK_SR_READY])) begin
          state_nxt = FLBLK_DONE;
        end
      end
      default: begin
        state_nxt = FLBLK_IDLE;
      end
    endcase
  end
  // Sequencer and counters
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= FLBLK_IDLE;
      cnt_r <= 5'h00;
      step_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r || strobe_done) ? 5'h00 : cnt_r + 5'h01;
      if (state_r == FLBLK_IDLE) begin
        step_r <= 2'h0;
      end else if (state_r == FLBLK_WR_GAP) begin
        step_r <= step_r + 2'h1;
      end
    end
  end
  // Software control registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      op_r <= 3'h0;
      tgt_addr_r <= 22'h000000;
      wp_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        wp_r <= reg_wdata[`FLBLK_CTRL_WP];
      end
      if (go) begin
        op_r <= reg_wdata[`FLBLK_CTRL_CMD_HI:`FLBLK_CTRL_CMD_LO];
      end
      if (wr_addr && !busy_r) begin
        tgt_addr_r <= reg_wdata[21:0];
      end
      busy_r <= go || (busy_r && state_r != FLBLK_DONE);
    end
  end
  // Capture of read results
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      result_r <= 16'h0000;
      err_bad_seq_r <= 1'b0;
      avail_r <= 1'b0;
      part_r <= 3'h0;
      lock_r <= 2'h0;
    end else if (state_r == FLBLK_RD && state_nxt == FLBLK_DONE) begin
      case (op_e)
        FLBLK_OP_READ_SR: begin
          // Bits 7..1 carry ready, suspend, error, supply, lock abort [R7] [R8] [R9]
          result_r <= sr_m; // [R10] [R11] [R12] [R13] [R18] [R19]
          err_bad_seq_r <= bad_seq;
        end
        FLBLK_OP_PAGE_CHECK: begin
          // Zero means software issues the check again [R20] [R21]
          result_r <= xsr_m;
          avail_r <= xsr_m[`FLBLK_XSR_AVAIL];
        end
        FLBLK_OP_READ_PCR: begin
          // Partition field only; its reset default is the device's own [R23] [R24]
          result_r <= dq_s & 16'h0700;
          part_r <= dq_s[`FLBLK_PCR_HI:`FLBLK_PCR_LO];
        end
        default: begin
          // Lock code: bit 0 locked, bit 1 locked down [R25]
          result_r <= dq_s & 16'h0003;
          lock_r <= dq_s[1:0];
        end
      endcase
    end
  end
  // Flash pins, all from flip-flops; write-protect level drives lock state [R5] [R6] [R26]
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flash_addr <= 22'h000000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_wp_n <= 1'b0;
    end else begin
      flash_wp_n <= wp_r;
      flash_addr <= (state_nxt == FLBLK_RD) ? rd_addr : tgt_addr_r;
      flash_dq_out <= wcmd;
      flash_dq_oe_n <= !(state_nxt == FLBLK_WR);
      // Strobe waits one cycle, then falls on the same edge that loads the command word
      flash_we_n <= !(state_nxt == FLBLK_WR && state_r == FLBLK_WR);
      flash_oe_n <= !(state_nxt == FLBLK_RD);
      flash_ce_n <= !(state_nxt == FLBLK_WR || state_nxt == FLBLK_RD);
    end
  end
  // Read mux on the local port, data in the cycle after the strobe
  wire [31:0] rd_mux =
    (reg_addr == `FLBLK_REG_CTRL) ? {27'h0, wp_r, op_r, busy_r} :
    (reg_addr == `FLBLK_REG_ADDR) ? {10'h000, tgt_addr_r} :
    (reg_addr == `FLBLK_REG_RESULT) ? {16'h0000, result_r} :
    (reg_addr == `FLBLK_REG_STATUS) ? {26'h0, rb_s, avail_r, err_bad_seq_r, part_r} :
    (reg_addr == `FLBLK_REG_LOCK) ? {30'h0, lock_r} : 32'h00000000;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end
endmodule : flblk_host

// [flblk_host_asserts.sv]
// Port checks for the flash lock host controller
`timescale 1ns/100ps
module flblk_host_asserts (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic [15:0] flash_dq_in,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_wp_n,
  input wire logic ready_busy_n_output
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [4:0] we_cnt_r; // Low cycles of the current write strobe
  // Counts strobe width so one check covers all 15 cycles
  always_ff @(posedge sys_clk) begin
    if (reset || flash_we_n) we_cnt_r <= 5'h00;
    else we_cnt_r <= we_cnt_r + 5'h01;
  end
  a_rdata_quiet: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside slot");
  a_strobe_excl: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("write and read strobes overlap");
  a_we_drives: assert property (!flash_we_n |-> !flash_ce_n && !flash_dq_oe_n)
    else $error("write strobe without select or drive");
  a_we_width: assert property ($rose(flash_we_n) |-> we_cnt_r == 5'h0F)
    else $error("write strobe width");
  a_addr_hold: assert property (!flash_we_n && !$past(flash_we_n)
    |-> $stable(flash_addr) && $stable(flash_dq_out)) else $error("bus moved in strobe");
  a_lock_confirm: assert property ($rose(flash_we_n) && $past(flash_dq_out) == 16'h0060
    |-> ##[1:3] (!flash_we_n && flash_dq_out inside {16'h0001, 16'h00D0, 16'h002F}))
    else $error("setup without confirm");
  a_wp_follow: assert property (reg_wr && reg_addr == 4'h0
    |-> ##2 flash_wp_n == $past(reg_wdata[4], 2)) else $error("protect pin level");
  a_reset_idle: assert property ($fell(reset)
    |-> flash_we_n && flash_oe_n && flash_ce_n && !flash_wp_n) else $error("idle after reset");
endmodule : flblk_host_asserts

// [flblk_pkg.sv]
// Types for the flash lock and status host controller
package flblk_pkg;
  // Host operations that software may start
  typedef enum logic [2:0] {
    FLBLK_OP_READ_SR,
    FLBLK_OP_LOCK_SET,
    FLBLK_OP_LOCK_CLR,
    FLBLK_OP_LOCK_DOWN,
    FLBLK_OP_READ_LOCK,
    FLBLK_OP_READ_PCR,
    FLBLK_OP_PAGE_CHECK,
    FLBLK_OP_CLR_SR
  } flblk_op_t;
  // Bus cycle sequencer states
  typedef enum logic [2:0] {
    FLBLK_IDLE,
    FLBLK_WR,
    FLBLK_WR_GAP,
    FLBLK_RD,
    FLBLK_DONE
  } flblk_state_t;
endpackage : flblk_pkg

// [flblk_sync.sv]
// Two flip-flop synchroniser for pins from the flash
`timescale 1ns/100ps
module flblk_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r; // First stage, read only by q
  // Plain two-stage chain
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : flblk_sync

// [flblk_tb.sv]
// Self-checking bench for the flash lock host controller
`timescale 1ns/100ps
`include "flblk_defs.svh"
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  logic [21:0] f_addr;
  logic [15:0] f_dq_out, f_dq_in;
  logic f_oe_dq_n, f_ce_n, f_oe_n, f_we_n, f_wp_n, f_rb_n;
  logic wp = 1'b0; // Protect level kept in every control write
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  flblk_host u_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_addr(f_addr), .flash_dq_out(f_dq_out), .flash_dq_oe_n(f_oe_dq_n),
    .flash_dq_in(f_dq_in), .flash_ce_n(f_ce_n), .flash_oe_n(f_oe_n),
    .flash_we_n(f_we_n), .flash_wp_n(f_wp_n), .ready_busy_n_output(f_rb_n));
  flblk_flash_model u_flash (.flash_addr(f_addr), .flash_dq_out(f_dq_out),
    .flash_ce_n(f_ce_n), .flash_oe_n(f_oe_n), .flash_we_n(f_we_n),
    .flash_wp_n(f_wp_n), .flash_dq_in(f_dq_in), .ready_busy_n_output(f_rb_n));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Start an operation and poll busy under a bound
  task run(input logic [2:0] op);
    int n;
    n = 0;
    wr(`FLBLK_REG_CTRL, {27'h0, wp, op, 1'b1});
    d = 32'h1;
    while (d[0] !== 1'b0 && n < 500) begin
      rd(`FLBLK_REG_CTRL);
      n++;
    end
    chk({31'h0, d[0]}, 32'h0);
  endtask : run
  task cmd(input logic [2:0] o, input logic [21:0] a);
    wr(`FLBLK_REG_ADDR, {10'h0, a});
    run(o);
  endtask : cmd
  task lk(input logic [21:0] a, input logic [1:0] e);
    cmd(3'h4, a);
    rd(`FLBLK_REG_LOCK);
    chk(d, {30'h0, e});
  endtask : lk
  task setwp(input logic v);
    wp = v;
    wr(`FLBLK_REG_CTRL, {27'h0, v, 4'h0});
    repeat (4) @(posedge sys_clk);
  endtask : setwp
  task t_cmd;
    cmd(3'h2, 22'h010000);
    lk(22'h010000, 2'b00);
    cmd(3'h1, 22'h010000);
    cmd(3'h1, 22'h010000);
    lk(22'h010000, 2'b01);
    cmd(3'h2, 22'h010000);
    cmd(3'h3, 22'h010000);
    lk(22'h010000, 2'b11);
    cmd(3'h2, 22'h010000);
    lk(22'h010000, 2'b11);
    lk(22'h000000, 2'b01);
  endtask : t_cmd
  task t_wp;
    setwp(1'b1);
    lk(22'h010000, 2'b11);
    cmd(3'h2, 22'h010000);
    lk(22'h010000, 2'b10);
    cmd(3'h3, 22'h010000);
    lk(22'h010000, 2'b11);
    cmd(3'h2, 22'h010000);
    cmd(3'h2, 22'h000000);
    setwp(1'b0);
    lk(22'h010000, 2'b11);
    lk(22'h000000, 2'b00);
    setwp(1'b1);
    lk(22'h010000, 2'b10);
    setwp(1'b0);
  endtask : t_wp
  task t_stat;
    cmd(3'h1, 22'h000000);
    rd(`FLBLK_REG_STATUS);
    chk({31'h0, d[5]}, 32'h0);
    run(3'h0);
    rd(`FLBLK_REG_RESULT);
    chk(d, 32'h80);
    rd(`FLBLK_REG_STATUS);
    chk({29'h0, d[5:3]}, 32'h4);
    run(3'h7);
    run(3'h0);
    rd(`FLBLK_REG_RESULT);
    chk(d, 32'h80);
    cmd(3'h5, 22'h0);
    rd(`FLBLK_REG_STATUS);
    chk({29'h0, d[2:0]}, 32'h1);
    run(3'h6);
    rd(`FLBLK_REG_RESULT);
    chk(d, 32'h80);
    rd(`FLBLK_REG_STATUS);
    chk({31'h0, d[4]}, 32'h1);
    run(3'h6);
    rd(`FLBLK_REG_STATUS);
    chk({31'h0, d[4]}, 32'h0);
    run(3'h6);
    rd(`FLBLK_REG_STATUS);
    chk({31'h0, d[4]}, 32'h1);
    rd(4'hF);
    chk(d, 32'h0);
  endtask : t_stat
  task results;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    lk(22'h0, 2'b01);
    t_cmd;
    t_wp;
    t_stat;
    results;
  end
  // Cut a hang short well past the expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results;
    end
  end
endmodule : testbench
bind flblk_host flblk_host_asserts u_chk (.sys_clk(sys_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_wp_n(flash_wp_n),
  .ready_busy_n_output(ready_busy_n_output));
